// ---- drive_parameter_store_control.sv ----
/*
 * parameter store of the drive: array, lock, restore, set choice and image transfer.
 * assumes a plain register port whose master keeps strobes one cycle long and never
 * raises both at once; keypad type and terminal levels are synchronous to the clock.
 */
// Implementation choices: the strobed register port and the register addresses.
module drive_parameter_store_control (
	input wire logic i_ref_clk, // 250 mhz clock
	input wire logic i_nrst, // synchronous reset, active low
	input wire logic [param_store_pkg::ADDR_W-1:0] i_addr, // register address
	input wire logic [param_store_pkg::DATA_W-1:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	input wire logic [param_store_pkg::MFI_W-1:0] i_mfi, // multifunction input levels
	input wire logic i_kp_lcd, // display keypad attached, else segment keypad
	output logic [param_store_pkg::DATA_W-1:0] o_rdata, // read data, cycle after the strobe
	output logic o_locked, // lock indicator for the dashed cursor
	output logic o_alt_active, // alternate motor set in force
	output logic o_alt_visible, // alternate items reachable
	output logic o_init_busy // restore in progress
);
	// ----------------------------------------------------------------
	// storage and state
	// ----------------------------------------------------------------
	localparam int DEPTH = 1 << param_store_pkg::PIDX_W;
	logic [param_store_pkg::DATA_W-1:0] mem [DEPTH];
	logic [param_store_pkg::DATA_W-1:0] rdata_ff;
	logic locked_ff;
	logic alt_active_ff;
	logic alt_visible_ff;
	logic init_busy_ff;
	logic [3:0] init_sel_ff;
	logic [2:0] alt_assign_ff;
	logic [param_store_pkg::PIDX_W-1:0] img_ptr_ff;
	param_store_pkg::img_state_t img_ff;
	param_store_pkg::img_state_t nxt_img;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic [1:0] space = i_addr[11:10];
	wire logic [param_store_pkg::PIDX_W-1:0] pidx = i_addr[9:0];
	wire logic [2:0] grp = pidx[9:7];
	wire logic [6:0] code = pidx[6:0];
	wire logic in_direct = (space == param_store_pkg::SPACE_DIRECT) &&
		(grp != param_store_pkg::GRP_NONE);
	wire logic in_effect = (space == param_store_pkg::SPACE_EFFECT) &&
		(grp != param_store_pkg::GRP_NONE);
	wire logic in_ctrl = (space == param_store_pkg::SPACE_CTRL);
	wire logic in_fu2 = in_direct && (grp == param_store_pkg::GRP_FUNC2);
	wire logic at_upload = in_fu2 && (code == param_store_pkg::CODE_UPLOAD);
	wire logic at_download = in_fu2 && (code == param_store_pkg::CODE_DOWNLOAD);
	wire logic at_init = in_fu2 && (code == param_store_pkg::CODE_INIT);
	wire logic at_lock = in_fu2 && (code == param_store_pkg::CODE_LOCK);
	wire logic at_cmd = at_upload || at_download || at_init;
	wire logic at_assign = in_ctrl && (pidx == param_store_pkg::CTRL_ALT_ASSIGN);
	wire logic at_status = in_ctrl && (pidx == param_store_pkg::CTRL_STATUS);
	wire logic at_image = in_ctrl && (pidx == param_store_pkg::CTRL_IMAGE);

	// ----------------------------------------------------------------
	// set choice
	// ----------------------------------------------------------------
	logic alt_active;
	logic alt_visible;
	logic is_alt;
	logic [param_store_pkg::PIDX_W-1:0] map_idx;
	alt_set_mapper u_mapper (
		.i_mfi(i_mfi),
		.i_assign(alt_assign_ff),
		.i_pidx(pidx),
		.o_active(alt_active),
		.o_visible(alt_visible),
		.o_is_alt(is_alt),
		.o_map(map_idx)
	);
	wire logic alt_hidden = is_alt && !alt_visible;

	// ----------------------------------------------------------------
	// restore sequencer
	// ----------------------------------------------------------------
	logic seq_busy;
	logic seq_done;
	mem_wr_if seq_wr ();
	wire logic sel_valid = (i_wdata >= 16'(param_store_pkg::INIT_ALL)) &&
		(i_wdata <= 16'(param_store_pkg::INIT_GRP_LAST));
	wire logic init_go = i_wr && at_init && sel_valid && !locked_ff && !seq_busy;
	restore_sequencer u_seq (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_start(init_go),
		.i_sel(i_wdata[3:0]),
		.o_busy(seq_busy),
		.o_done(seq_done),
		.wr(seq_wr.src)
	);

	// ----------------------------------------------------------------
	// write qualification
	// ----------------------------------------------------------------
	wire logic open_for_edit = !locked_ff || at_lock;
	wire logic param_wr = i_wr && in_direct && !at_cmd && !alt_hidden &&
		!seq_busy && open_for_edit;
	wire logic lock_toggle = i_wr && at_lock && (i_wdata == param_store_pkg::LOCK_KEY);
	wire logic img_wr = i_wr && at_image && (img_ff == param_store_pkg::IMG_DOWNLOAD) &&
		!locked_ff && !seq_busy;
	wire logic img_rd = i_rd && at_image && (img_ff == param_store_pkg::IMG_UPLOAD);
	wire logic img_step = img_wr || img_rd;
	wire logic img_end = img_step && (img_ptr_ff == param_store_pkg::IMAGE_LAST);
	wire logic cmd_on = (i_wdata == param_store_pkg::CMD_START);
	wire logic up_go = i_wr && at_upload && cmd_on && i_kp_lcd && !seq_busy;
	wire logic down_go = i_wr && at_download && cmd_on && i_kp_lcd &&
		!seq_busy && !locked_ff;
	wire logic img_stop = i_wr && (at_upload || at_download) && !cmd_on;

	// ----------------------------------------------------------------
	// parameter array
	// ----------------------------------------------------------------
	// the restore owns the write port while running, so bus edits are refused then
	always_ff @(posedge i_ref_clk) begin
		if (seq_wr.req) begin
			mem[seq_wr.addr] <= seq_wr.data;
		end else if (param_wr) begin
			mem[pidx] <= i_wdata;
		end else if (img_wr) begin
			mem[img_ptr_ff] <= i_wdata;
		end
	end

	// ----------------------------------------------------------------
	// lock state
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			locked_ff <= 1'b0;
		end else if (lock_toggle) begin
			locked_ff <= !locked_ff;
		end
	end

	// ----------------------------------------------------------------
	// initialize selector
	// ----------------------------------------------------------------
	// the pass out of reset reports itself as an all-groups restore
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			init_sel_ff <= param_store_pkg::INIT_ALL;
		end else if (init_go) begin
			init_sel_ff <= i_wdata[3:0];
		end else if (seq_done) begin
			init_sel_ff <= param_store_pkg::INIT_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// alternate-set assignment
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			alt_assign_ff <= param_store_pkg::ALT_ASSIGN_RST;
		end else if (i_wr && at_assign) begin
			alt_assign_ff <= i_wdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// image transfer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_img = img_ff;
		case (img_ff)
			param_store_pkg::IMG_IDLE: begin
				if (up_go) begin
					nxt_img = param_store_pkg::IMG_UPLOAD;
				end else if (down_go) begin
					nxt_img = param_store_pkg::IMG_DOWNLOAD;
				end
			end
			param_store_pkg::IMG_UPLOAD, param_store_pkg::IMG_DOWNLOAD: begin
				// a segment keypad in place of the display keypad drops the transfer
				if (img_end || img_stop || !i_kp_lcd || seq_busy) begin
					nxt_img = param_store_pkg::IMG_IDLE;
				end
			end
			default: begin
				nxt_img = param_store_pkg::IMG_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			img_ff <= param_store_pkg::IMG_IDLE;
		end else begin
			img_ff <= nxt_img;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			img_ptr_ff <= '0;
		end else if (up_go || down_go) begin
			img_ptr_ff <= '0;
		end else if (img_step) begin
			img_ptr_ff <= 10'(img_ptr_ff + 10'h001);
		end
	end

	// ----------------------------------------------------------------
	// read selection
	// ----------------------------------------------------------------
	wire logic [15:0] status_word = {
		10'h000,
		(img_ff != param_store_pkg::IMG_IDLE),
		i_kp_lcd,
		seq_busy,
		alt_visible,
		alt_active,
		locked_ff
	};
	wire logic [15:0] cmd_word = at_init ? {12'h000, init_sel_ff} :
		at_upload ? {15'h0000, (img_ff == param_store_pkg::IMG_UPLOAD)} :
		{15'h0000, (img_ff == param_store_pkg::IMG_DOWNLOAD)};
	wire logic [15:0] direct_word = alt_hidden ? 16'h0000 :
		at_cmd ? cmd_word : mem[pidx];
	wire logic [15:0] effect_word = mem[map_idx];
	wire logic [15:0] ctrl_word = at_assign ? {13'h0000, alt_assign_ff} :
		at_status ? status_word :
		img_rd ? mem[img_ptr_ff] : 16'h0000;
	wire logic [15:0] read_word = in_direct ? direct_word :
		in_effect ? effect_word :
		in_ctrl ? ctrl_word : 16'h0000;

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= i_rd ? read_word : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// output flops
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			alt_active_ff <= 1'b0;
			alt_visible_ff <= 1'b0;
			init_busy_ff <= 1'b1;
		end else begin
			alt_active_ff <= alt_active;
			alt_visible_ff <= alt_visible;
			init_busy_ff <= seq_busy;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_locked = locked_ff;
	assign o_alt_active = alt_active_ff;
	assign o_alt_visible = alt_visible_ff;
	assign o_init_busy = init_busy_ff;
endmodule : drive_parameter_store_control

// ---- param_store_pkg.sv ----
/*
 * constants, field layouts and state types of the drive parameter store.
 * assumes one 250 mhz clock and a synchronous active-low reset in every user.
 */
package param_store_pkg;
	// ----------------------------------------------------------------
	// widths and address spaces
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 12;
	localparam int PIDX_W = 10;
	localparam int MFI_W = 3;
	localparam logic [1:0] SPACE_DIRECT = 2'h0;
	localparam logic [1:0] SPACE_EFFECT = 2'h1;
	localparam logic [1:0] SPACE_CTRL = 2'h2;
	localparam logic [9:0] CTRL_ALT_ASSIGN = 10'h000;
	localparam logic [9:0] CTRL_STATUS = 10'h001;
	localparam logic [9:0] CTRL_IMAGE = 10'h002;
	localparam logic [9:0] IMAGE_LAST = 10'h3ff;
	// ----------------------------------------------------------------
	// groups and codes
	// ----------------------------------------------------------------
	localparam logic [2:0] GRP_DRIVE = 3'h0;
	localparam logic [2:0] GRP_FUNC1 = 3'h1;
	localparam logic [2:0] GRP_FUNC2 = 3'h2;
	localparam logic [2:0] GRP_NONE = 3'h7;
	localparam logic [6:0] CODE_ACCEL = 7'h01;
	localparam logic [6:0] CODE_DECEL = 7'h02;
	localparam logic [6:0] CODE_BASE_FREQ = 7'h15;
	localparam logic [6:0] CODE_FWD_BOOST = 7'h1b;
	localparam logic [6:0] CODE_REV_BOOST = 7'h1c;
	localparam logic [6:0] CODE_VF_PATTERN = 7'h1d;
	localparam logic [6:0] CODE_THERM_1MIN = 7'h33;
	localparam logic [6:0] CODE_THERM_CONT = 7'h34;
	localparam logic [6:0] CODE_STALL = 7'h3c;
	localparam logic [6:0] CODE_RATED_CURR = 7'h21;
	localparam logic [6:0] CODE_ALT_FIRST = 7'h51;
	localparam logic [6:0] CODE_ALT_LAST = 7'h5a;
	localparam logic [6:0] CODE_UPLOAD = 7'h5b;
	localparam logic [6:0] CODE_DOWNLOAD = 7'h5c;
	localparam logic [6:0] CODE_INIT = 7'h5d;
	localparam logic [6:0] CODE_LOCK = 7'h5e;
	// ----------------------------------------------------------------
	// values and status bits
	// ----------------------------------------------------------------
	localparam logic [3:0] INIT_IDLE = 4'h0;
	localparam logic [3:0] INIT_ALL = 4'h1;
	localparam logic [3:0] INIT_GRP_FIRST = 4'h2;
	localparam logic [3:0] INIT_GRP_LAST = 4'h8;
	localparam logic [15:0] LOCK_KEY = 16'h000c;
	localparam logic [15:0] CMD_START = 16'h0001;
	localparam logic [15:0] PARAM_DEFAULT = 16'h0000;
	localparam logic [2:0] ALT_ASSIGN_RST = 3'h0;
	localparam int ST_LOCKED = 0;
	localparam int ST_ALT_ACTIVE = 1;
	localparam int ST_ALT_VISIBLE = 2;
	localparam int ST_INIT_BUSY = 3;
	localparam int ST_LCD = 4;
	localparam int ST_IMAGE = 5;
	typedef enum logic [1:0] {
		IMG_IDLE = 2'b00,
		IMG_UPLOAD = 2'b01,
		IMG_DOWNLOAD = 2'b11
	} img_state_t;
endpackage : param_store_pkg

// ---- mem_wr_if.sv ----
/*
 * write request carrier from the restore sequencer to the parameter array.
 * assumes the array accepts one write per cycle with no back-pressure.
 */
interface mem_wr_if;
	logic req;
	logic [param_store_pkg::PIDX_W-1:0] addr;
	logic [param_store_pkg::DATA_W-1:0] data;
	modport src (output req, output addr, output data);
	modport dst (input req, input addr, input data);
endinterface : mem_wr_if

// ---- alt_set_mapper.sv ----
/*
 * combinational choice between primary and alternate motor items.
 * assumes the caller registers whatever leaves the top module.
 */
module alt_set_mapper (
	input wire logic [param_store_pkg::MFI_W-1:0] i_mfi, // terminal levels
	input wire logic [param_store_pkg::MFI_W-1:0] i_assign, // terminals assigned to set choice
	input wire logic [param_store_pkg::PIDX_W-1:0] i_pidx, // parameter index
	output logic o_active, // alternate set in force
	output logic o_visible, // alternate items reachable
	output logic o_is_alt, // index lies among alternate items
	output logic [param_store_pkg::PIDX_W-1:0] o_map // index of value in force
);
	// ----------------------------------------------------------------
	// shadow table
	// ----------------------------------------------------------------
	function automatic logic [7:0] alt_of(input logic [9:0] p);
		case (p)
			{param_store_pkg::GRP_DRIVE, param_store_pkg::CODE_ACCEL}: alt_of = 8'h81;
			{param_store_pkg::GRP_DRIVE, param_store_pkg::CODE_DECEL}: alt_of = 8'h82;
			{param_store_pkg::GRP_FUNC1, param_store_pkg::CODE_BASE_FREQ}: alt_of = 8'h83;
			{param_store_pkg::GRP_FUNC1, param_store_pkg::CODE_VF_PATTERN}: alt_of = 8'h84;
			{param_store_pkg::GRP_FUNC1, param_store_pkg::CODE_FWD_BOOST}: alt_of = 8'h85;
			{param_store_pkg::GRP_FUNC1, param_store_pkg::CODE_REV_BOOST}: alt_of = 8'h86;
			{param_store_pkg::GRP_FUNC1, param_store_pkg::CODE_STALL}: alt_of = 8'h87;
			{param_store_pkg::GRP_FUNC1, param_store_pkg::CODE_THERM_1MIN}: alt_of = 8'h88;
			{param_store_pkg::GRP_FUNC1, param_store_pkg::CODE_THERM_CONT}: alt_of = 8'h89;
			{param_store_pkg::GRP_FUNC2, param_store_pkg::CODE_RATED_CURR}: alt_of = 8'h8a;
			default: alt_of = 8'h00; // user v/f points and the rest stay shared
		endcase
	endfunction : alt_of

	// ----------------------------------------------------------------
	// selection
	// ----------------------------------------------------------------
	wire logic [7:0] hit_code = alt_of(i_pidx);
	wire logic [6:0] code = i_pidx[6:0];
	assign o_active = |(i_mfi & i_assign);
	assign o_visible = |i_assign;
	assign o_is_alt = (i_pidx[9:7] == param_store_pkg::GRP_FUNC2) &&
		(code >= param_store_pkg::CODE_ALT_FIRST) && (code <= param_store_pkg::CODE_ALT_LAST);
	assign o_map = (hit_code[7] && o_active) ?
		{param_store_pkg::GRP_FUNC2, 7'(8'h50 + {4'h0, hit_code[3:0]})} : i_pidx;
endmodule : alt_set_mapper

// ---- restore_sequencer.sv ----
/*
 * walks the parameter array writing factory values, for all groups or one.
 * assumes the array takes its write every cycle; starts an all-groups pass out of reset.
 */
module restore_sequencer (
	input wire logic i_ref_clk, // 250 mhz clock
	input wire logic i_nrst, // synchronous reset, active low
	input wire logic i_start, // one-cycle start request
	input wire logic [3:0] i_sel, // selector value 1 to 8
	output logic o_busy, // restore in progress
	output logic o_done, // one-cycle pulse in the cycle after the last write
	mem_wr_if.src wr // write requests to the array
);
	logic busy_ff;
	logic all_ff;
	logic done_ff;
	logic [param_store_pkg::PIDX_W-1:0] addr_ff;
	// ----------------------------------------------------------------
	// walk
	// ----------------------------------------------------------------
	wire logic last = all_ff ? (addr_ff == param_store_pkg::IMAGE_LAST) : (&addr_ff[6:0]);
	wire logic [2:0] grp = 3'(i_sel - param_store_pkg::INIT_GRP_FIRST);
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			busy_ff <= 1'b1;
			all_ff <= 1'b1;
			done_ff <= 1'b0;
			addr_ff <= '0;
		end else if (!busy_ff && i_start) begin
			busy_ff <= 1'b1;
			all_ff <= (i_sel == param_store_pkg::INIT_ALL);
			addr_ff <= (i_sel == param_store_pkg::INIT_ALL) ? '0 : {grp, 7'h00};
			done_ff <= 1'b0;
		end else begin
			done_ff <= busy_ff && last;
			busy_ff <= busy_ff && !last;
			addr_ff <= busy_ff ? 10'(addr_ff + 10'h001) : addr_ff;
		end
	end
	assign wr.req = busy_ff;
	assign wr.addr = addr_ff;
	assign wr.data = param_store_pkg::PARAM_DEFAULT;
	assign o_busy = busy_ff;
	assign o_done = done_ff;
endmodule : restore_sequencer

// ---- drive_parameter_store_control_asserts.sv ----
/* port checker of the parameter store.
   assumes the register master leaves a gap cycle before every strobe. */
module drive_parameter_store_control_asserts (
	input wire logic i_ref_clk, // clock
	input wire logic i_nrst, // reset, active low
	input wire logic [11:0] i_addr, // address
	input wire logic [15:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	input wire logic [2:0] i_mfi, // terminal levels
	input wire logic i_kp_lcd, // keypad type
	input wire logic [15:0] o_rdata, // read data
	input wire logic o_locked, // lock indicator
	input wire logic o_alt_active, // alternate set in force
	input wire logic o_alt_visible, // alternate items shown
	input wire logic o_init_busy // restore running
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	// ----
	// rules
	// ----
	a_lock_toggle: assert property (i_wr && i_addr == 12'h15e && i_wdata == 16'h000c
		&& !o_init_busy |=> o_locked != $past(o_locked)) else $error("lock did not toggle");
	a_lock_hold: assert property (!(i_wr && i_addr == 12'h15e && i_wdata == 16'h000c)
		|=> $stable(o_locked)) else $error("lock moved without key");
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside read cycle");
	a_alt_idle: assert property (i_mfi == 3'h0 |=> !o_alt_active)
		else $error("alternate set with terminals low");
	a_alt_shown: assert property (o_alt_active |-> o_alt_visible)
		else $error("alternate set in force while hidden");
	a_alt_hidden: assert property (i_rd && i_addr inside {[12'h151:12'h15a]}
		&& !o_alt_visible && !$past(i_wr) |=> o_rdata == 16'h0000)
		else $error("hidden alternate item read");
	a_init_idle: assert property (i_rd && i_addr == 12'h15d && !o_init_busy
		&& !$past(i_wr) |=> o_rdata == 16'h0000) else $error("selector not idle");
	a_init_group: assert property (i_wr && i_addr == 12'h15d && i_wdata inside {[16'h2:16'h8]}
		&& !o_locked && !o_init_busy && !$past(i_wr) |-> ##2 o_init_busy ##[120:135] !o_init_busy)
		else $error("group restore length wrong");
	a_init_refused: assert property (i_wr && i_addr == 12'h15d && !o_init_busy && !$past(i_wr)
		&& (o_locked || !(i_wdata inside {[16'h1:16'h8]})) |-> ##2 !o_init_busy)
		else $error("refused restore started");
	a_status_read: assert property (i_rd && i_addr == 12'h801
		|=> o_rdata[0] == $past(o_locked)) else $error("status lock bit wrong");
endmodule : drive_parameter_store_control_asserts

bind drive_parameter_store_control drive_parameter_store_control_asserts chk (
	.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .i_mfi(i_mfi), .i_kp_lcd(i_kp_lcd), .o_rdata(o_rdata), .o_locked(o_locked),
	.o_alt_active(o_alt_active), .o_alt_visible(o_alt_visible), .o_init_busy(o_init_busy));

// ---- keypad_terminal_model.sv ----
/* terminals and keypad on the far side of the parameter store.
   assumes the bench names wanted levels; they reach the pins one edge later. */
module keypad_terminal_model (
	input wire logic i_ref_clk, // clock
	input wire logic [2:0] i_mfi_set, // wanted terminal levels
	input wire logic i_lcd_set, // wanted keypad type
	output logic [2:0] o_mfi, // terminal levels
	output logic o_kp_lcd // display keypad attached
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// pins
	// ----
	initial begin
		o_mfi = 3'h0;
		o_kp_lcd = 1'b0;
	end
	always @(posedge i_ref_clk) begin
		o_mfi <= i_mfi_set;
		o_kp_lcd <= i_lcd_set;
	end
endmodule : keypad_terminal_model

// ---- drive_parameter_store_control_bench.sv ----
/* self-checking bench of the parameter store.
   assumes the keypad model's pins follow the bench one edge later. */
module drive_parameter_store_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] mfi_set = 3'h0;
	logic lcd_set = 1'b0;
	logic [2:0] mfi;
	logic kp_lcd;
	logic [15:0] rdata;
	logic locked;
	logic alt_on;
	logic alt_vis;
	logic busy;
	logic [15:0] v;
	logic [9:0] prim [10];
	int errors = 0;
	int checked = 0;
	keypad_terminal_model far (.i_ref_clk(clk), .i_mfi_set(mfi_set), .i_lcd_set(lcd_set),
		.o_mfi(mfi), .o_kp_lcd(kp_lcd));
	drive_parameter_store_control DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_mfi(mfi), .i_kp_lcd(kp_lcd), .o_rdata(rdata),
		.o_locked(locked), .o_alt_active(alt_on), .o_alt_visible(alt_vis), .o_init_busy(busy));
	initial begin
		forever #2 clk = ~clk;
	end
	// ----
	// tasks
	// ----
	task automatic end_sim();
		if (errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wreg(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask : wreg
	task automatic rchk(input logic [11:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(rdata, e);
	endtask : rchk
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (busy !== lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (busy !== lvl) begin
			errors++;
			$display("mismatch at %0t: wait ran out", $time);
			end_sim();
		end
	endtask : wait_busy
	// ----
	// sequence
	// ----
	initial begin
		prim = '{10'h001, 10'h002, 10'h095, 10'h09d, 10'h09b, 10'h09c, 10'h0bc, 10'h0b3,
			10'h0b4, 10'h121};
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		wait_busy(1'b0, 1100);
		rchk(12'h15d, 16'h0000);
		wreg(12'h151, 16'h2222);
		rchk(12'h151, 16'h0000);
		wreg(12'h800, 16'h0001);
		for (int k = 0; k < 10; k++) begin
			wreg({2'h0, prim[k]}, 16'h1000 + 16'(k));
			wreg(12'h151 + 12'(k), 16'h2000 + 16'(k));
		end
		wreg(12'h003, 16'h0abc);
		wreg(12'h09e, 16'h0def);
		for (int m = 0; m < 4; m++) begin
			mfi_set <= m[2:0];
			repeat (3) @(negedge clk);
			check({15'h0, alt_on}, {15'h0, m[0]});
			for (int k = 0; k < 10; k++) begin
				rchk(12'h400 | {2'h0, prim[k]}, (m[0] ? 16'h2000 : 16'h1000) + 16'(k));
			end
			rchk(12'h403, 16'h0abc);
			rchk(12'h49e, 16'h0def);
		end
		wreg(12'h800, 16'h0000);
		mfi_set <= 3'h1;
		repeat (3) @(negedge clk);
		check({15'h0, alt_vis}, 16'h0000);
		rchk(12'h401, 16'h1000);
		rchk(12'h151, 16'h0000);
		wreg(12'h15e, 16'h0005);
		check({15'h0, locked}, 16'h0000);
		wreg(12'h15e, 16'h000c);
		check({15'h0, locked}, 16'h0001);
		rchk(12'h801, 16'h0001);
		wreg(12'h003, 16'h1111);
		rchk(12'h003, 16'h0abc);
		wreg(12'h15d, 16'h0002);
		repeat (3) @(negedge clk);
		check({15'h0, busy}, 16'h0000);
		wreg(12'h15e, 16'h0007);
		check({15'h0, locked}, 16'h0001);
		wreg(12'h15e, 16'h000c);
		check({15'h0, locked}, 16'h0000);
		for (int s = 0; s <= 9; s += 9) begin
			wreg(12'h15d, 16'(s));
			repeat (3) @(negedge clk);
			check({15'h0, busy}, 16'h0000);
		end
		for (int s = 1; s <= 8; s++) begin
			for (int g = 0; g < 7; g++) wreg({2'h0, 3'(g), 7'h05}, 16'h5a5a);
			wreg(12'h15d, 16'(s));
			wait_busy(1'b1, 5);
			rchk(12'h15d, 16'(s));
			wait_busy(1'b0, 1100);
			rchk(12'h15d, 16'h0000);
			for (int g = 0; g < 7; g++) begin
				rchk({2'h0, 3'(g), 7'h05}, (s == 1 || g == s - 2) ? 16'h0000 : 16'h5a5a);
			end
		end
		wreg(12'h0b0, 16'h0100);
		wreg(12'h000, 16'h0011);
		wreg(12'h15b, 16'h0001);
		rchk(12'h15b, 16'h0000);
		lcd_set <= 1'b1;
		wreg(12'h15b, 16'h0001);
		rchk(12'h15b, 16'h0001);
		rchk(12'h802, 16'h0011);
		rchk(12'h802, 16'h0000);
		// code 5 of groups 0 to 5 still holds the marker left by the group restores
		for (int i = 2; i < 1024; i++) begin
			v = (i % 128 == 5 && i < 768) ? 16'h5a5a : 16'h0000;
			rchk(12'h802, (i == 12'h0b0) ? 16'h0100 : v);
		end
		rchk(12'h15b, 16'h0000);
		wreg(12'h15c, 16'h0001);
		for (int i = 0; i < 1024; i++) begin
			wreg(12'h802, (i >= 12'h151 && i <= 12'h15e) ? 16'h0000 : 16'(i) + 16'h0001);
		end
		rchk(12'h15c, 16'h0000);
		rchk(12'h0c3, 16'h00c4);
		rchk(12'h3a5, 16'h0000);
		lcd_set <= 1'b0;
		wreg(12'h15c, 16'h0001);
		wreg(12'h802, 16'hdead);
		rchk(12'h000, 16'h0001);
		rchk(12'hc05, 16'h0000);
		end_sim();
	end
endmodule : drive_parameter_store_control_bench
